// [hw/jesl_top.sv]
// joint error stop link: follows another axis into error stop and passes own stop on
// assumes: apb master on core_clk; network receiver and motor logic on core_clk
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/10ps
`include "jesl_consts.svh"

// Functional notes
// RQ1 - follow monitored axis stop within one cycle
// RQ2 - 6-bit monitored device number, 0 to 63
// RQ3 - write-only joint-stop function enable bit
// RQ4 - receive enable bit lets peer stop us
// RQ5 - send enable bit passes own stop on
// RQ6 - software picks the slot just before ours
// RQ7 - software chains selections into a loop
// RQ8 - error stop is error interrupt while stopping
// RQ9 - stop state from target main status frames
// RQ10 - readable 8-bit error count, saturates 255
// RQ11 - command 0031h clears the error count
// RQ12 - defaults and reset clear the count
// RQ13 - 4-bit run limit, zero disables stop
// RQ14 - run reaching limit stops axis, raises error
// RQ15 - one good frame restarts the run
// RQ16 - status bit shows monitor-caused error stop
// RQ17 - missing or corrupt frame counts one error
module jesl_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cyclic network receiver
  input wire jesl_pkg::jesl_frame_t frame,
  input wire logic cycle_start,
  // local axis
  input wire logic own_err_irq,
  input wire logic own_stopping,
  output logic axis_err_stop,
  output logic axis_err_irq,
  output logic stop_req_out
);

  // register fields
  logic [5:0] target_r;
  logic sync_en_r;
  logic recv_en_r;
  logic send_en_r;
  logic [3:0] limit_r;
  logic js_status_r;
  logic js_status_nxt;
  logic axis_stop_r;
  logic axis_stop_nxt;
  logic stop_out_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // bus decode
  logic access;
  logic wr;
  logic rd;
  logic hit_cfg;
  logic hit_mode;
  logic hit_cnt;
  logic hit_cfg2;
  logic hit_stat;
  logic hit_cmd;
  logic mapped;
  logic clr_cmd;
  logic rd_take;
  logic rd_wait_r;

  // monitoring
  jesl_pkg::jesl_mon_t mon;
  logic [7:0] js_count;
  logic limit_hit;
  logic peer_stop;
  logic own_stop;

  // decode used for every register
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a[11:2] == ofs[11:2]);
  endfunction

  // apb decode; writes finish at once, reads take one wait state for flopped data
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign hit_cfg = addr_is(paddr, `JESL_OFS_SYNC_CONFIG);
  assign hit_mode = addr_is(paddr, `JESL_OFS_AXIS_MODE);
  assign hit_cnt = addr_is(paddr, `JESL_OFS_MON_ERR_COUNTS);
  assign hit_cfg2 = addr_is(paddr, `JESL_OFS_SYNC_CONFIG2);
  assign hit_stat = addr_is(paddr, `JESL_OFS_ERROR_STATUS);
  assign hit_cmd = addr_is(paddr, `JESL_OFS_COMMAND);
  assign mapped = hit_cfg | hit_mode | hit_cnt | hit_cfg2 | hit_stat | hit_cmd;
  // first read cycle captures the word, the second hands it over
  assign rd_take = rd & ~rd_wait_r;
  assign pready = ~rd | rd_wait_r;
  // unmapped addresses and writes to read-only words answer with an error
  assign pslverr = access & (~mapped | (pwrite & (hit_cnt | hit_stat)) |
                   (~pwrite & (hit_cfg | hit_mode | hit_cfg2 | hit_cmd)));

  // RQ11 clear command decode
  assign clr_cmd = wr & hit_cmd & pstrb[0] & pstrb[1] &
                   (pwdata[15:0] == `JESL_CMD_CLR_JS_COUNT);

  // RQ2 target number write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_r <= `JESL_RST_TARGET;
      sync_en_r <= 1'b0;
    end else if (wr & hit_cfg & pstrb[1]) begin
      target_r <= pwdata[`JESL_TARGET_MSB:`JESL_TARGET_LSB];
      // RQ3 function enable bit
      sync_en_r <= pwdata[`JESL_SYNC_EN_BIT];
    end
  end

  // RQ4 receive enable, RQ5 send enable; both sit in the top byte
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      recv_en_r <= 1'b0;
      send_en_r <= 1'b0;
    end else if (wr & hit_mode & pstrb[3]) begin
      recv_en_r <= pwdata[`JESL_RECV_EN_BIT];
      send_en_r <= pwdata[`JESL_SEND_EN_BIT];
    end
  end

  // RQ13 run limit field
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      limit_r <= `JESL_RST_LIMIT;
    end else if (wr & hit_cfg2 & pstrb[2]) begin
      limit_r <= pwdata[`JESL_LIMIT_MSB:`JESL_LIMIT_LSB];
    end
  end

  // RQ9 frame watch
  jesl_frame_watch u_watch (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sync_en(sync_en_r),
    .target_dev(target_r),
    .frame(frame),
    .cycle_start(cycle_start),
    .mon(mon)
  );

  // RQ10 error counting, RQ14 run limit
  jesl_err_count #(
    .TOTAL_W(8),
    .RUN_W(4)
  ) u_count (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ok(mon.ok),
    .err(mon.err),
    .clr_total(clr_cmd),
    .limit(limit_r),
    .total(js_count),
    .limit_hit(limit_hit)
  );

  // RQ1 peer stop follow; acted on the cycle after the target frame lands
  assign peer_stop = mon.err_stop & recv_en_r & sync_en_r;
  // RQ8 own error stop
  assign own_stop = own_err_irq & own_stopping;

  // RQ16 status set wins over read clear
  assign js_status_nxt = limit_hit | (js_status_r & ~(rd_take & hit_stat));
  // RQ14 stop pulse toward the motor
  assign axis_stop_nxt = peer_stop | limit_hit;

  // stop and status flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      js_status_r <= 1'b0;
      axis_stop_r <= 1'b0;
      axis_err_irq <= 1'b0;
    end else begin
      js_status_r <= js_status_nxt;
      axis_stop_r <= axis_stop_nxt;
      axis_err_irq <= limit_hit;
    end
  end

  // RQ5 send own stop; the status frame carries this level each cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_out_r <= 1'b0;
    end else begin
      stop_out_r <= own_stop & send_en_r & sync_en_r;
    end
  end

  // read mux; write-only words read as zero
  always_comb begin
    prdata_nxt = '0;
    if (rd_take & hit_cnt) begin
      prdata_nxt[`JESL_JS_COUNT_MSB:`JESL_JS_COUNT_LSB] = js_count;
    end
    if (rd_take & hit_stat) begin
      prdata_nxt[`JESL_JS_STATUS_BIT] = js_status_r;
    end
  end

  // read word is captured in the wait cycle, so the bus sees a flop, not the decode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= '0;
      rd_wait_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      rd_wait_r <= rd_take;
    end
  end

  assign prdata = prdata_r;
  assign axis_err_stop = axis_stop_r;
  assign stop_req_out = stop_out_r;

endmodule

// [common/jesl_consts.svh]
// offsets, field positions, reset values and command codes of the joint error stop link
// assumes: included by bare name from design files after the package
`ifndef JESL_CONSTS_SVH
`define JESL_CONSTS_SVH

// register byte addresses, one aligned word each
`define JESL_OFS_SYNC_CONFIG 12'h000
`define JESL_OFS_AXIS_MODE 12'h004
`define JESL_OFS_MON_ERR_COUNTS 12'h008
`define JESL_OFS_SYNC_CONFIG2 12'h00c
`define JESL_OFS_ERROR_STATUS 12'h010
`define JESL_OFS_COMMAND 12'h014

// field positions
`define JESL_TARGET_LSB 8
`define JESL_TARGET_MSB 13
`define JESL_SYNC_EN_BIT 14
`define JESL_RECV_EN_BIT 31
`define JESL_SEND_EN_BIT 30
`define JESL_JS_COUNT_LSB 8
`define JESL_JS_COUNT_MSB 15
`define JESL_LIMIT_LSB 16
`define JESL_LIMIT_MSB 19
`define JESL_JS_STATUS_BIT 20

// command code that clears the joint-stop monitoring error counter
`define JESL_CMD_CLR_JS_COUNT 16'h0031

// reset values and count maximum
`define JESL_RST_TARGET 6'h00
`define JESL_RST_LIMIT 4'h0
`define JESL_COUNT_MAX 8'hff

`endif

// [common/jesl_pkg.sv]
// types shared by the joint error stop link design
// assumes: compiled before any design file
package jesl_pkg;

  // one status frame seen on the cyclic network, as decoded by the receiver
  typedef struct packed {
    logic valid;      // one-cycle strobe, a frame has ended
    logic [5:0] dev;  // sender device number
    logic crc_ok;     // frame arrived intact
    logic err_stop;   // sender reports an error stop in its main status
  } jesl_frame_t;

  // monitoring result of one cyclic cycle
  typedef struct packed {
    logic ok;        // target frame received intact
    logic err;       // target frame missing or corrupted
    logic err_stop;  // target reports error stop (valid with ok)
  } jesl_mon_t;

endpackage

// [hw/jesl_frame_watch.sv]
// watches cyclic frames for the monitored axis and judges each cyclic cycle
// assumes: frame and cycle strobes come from the network receiver on core_clk
`timescale 1ns/10ps

module jesl_frame_watch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration
  input wire logic sync_en,
  input wire logic [5:0] target_dev,
  // network side
  input wire jesl_pkg::jesl_frame_t frame,
  input wire logic cycle_start,
  // result
  output jesl_pkg::jesl_mon_t mon
);

  logic seen_r;
  logic seen_nxt;
  logic hit;
  logic hit_ok;
  logic hit_bad;
  logic missed;
  jesl_pkg::jesl_mon_t mon_r;
  jesl_pkg::jesl_mon_t mon_nxt;

  // RQ9 target status frame
  assign hit = sync_en & frame.valid & (frame.dev == target_dev);
  assign hit_ok = hit & frame.crc_ok;
  // RQ17 corrupt frame error
  assign hit_bad = hit & ~frame.crc_ok;
  // RQ17 missing frame error; a cycle with no frame from the target counts once
  assign missed = sync_en & cycle_start & ~seen_r;

  // a new cycle restarts the search; a hit in that same cycle still counts
  assign seen_nxt = hit | (seen_r & ~cycle_start);
  assign mon_nxt.ok = hit_ok;
  assign mon_nxt.err = hit_bad | missed;
  assign mon_nxt.err_stop = hit_ok & frame.err_stop;

  // seen flag stays set until the next cycle starts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b1;
      mon_r <= '0;
    end else begin
      seen_r <= seen_nxt | ~sync_en;
      mon_r <= mon_nxt;
    end
  end

  assign mon = mon_r;

endmodule

// [hw/jesl_err_count.sv]
// saturating total error count and consecutive error run with a stop limit
// assumes: ok and err are one-cycle pulses, never both high together
`timescale 1ns/10ps
`include "jesl_consts.svh"

module jesl_err_count #(
  parameter int TOTAL_W = 8,
  parameter int RUN_W = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // events and controls
  input wire logic ok,
  input wire logic err,
  input wire logic clr_total,
  input wire logic [RUN_W-1:0] limit,
  // results
  output logic [TOTAL_W-1:0] total,
  output logic limit_hit
);

  logic [TOTAL_W-1:0] total_r;
  logic [TOTAL_W-1:0] total_nxt;
  logic [RUN_W-1:0] run_r;
  logic [RUN_W-1:0] run_nxt;
  logic total_full;
  logic run_reach;

  // RQ10 saturate at max
  assign total_full = (total_r == {TOTAL_W{1'b1}});
  // RQ11 clear on command; an error in the same cycle still counts
  assign total_nxt = err ? (clr_total ? TOTAL_W'(1) :
                     (total_full ? total_r : total_r + TOTAL_W'(1))) :
                     (clr_total ? '0 : total_r);
  // RQ14 limit reached
  assign run_reach = err & (limit != '0) & ((run_r + RUN_W'(1)) == limit);
  // RQ15 success restarts run; the run also restarts on the error that reaches the limit
  assign run_nxt = ok | run_reach ? '0 : (err ? run_r + RUN_W'(1) : run_r);

  // RQ12 default clears counts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      total_r <= '0;
      run_r <= '0;
      limit_hit <= 1'b0;
    end else begin
      total_r <= total_nxt;
      run_r <= run_nxt;
      limit_hit <= run_reach;
    end
  end

  assign total = total_r;

endmodule

// [test/jesl_peer_model.sv]
// peer axis model: cycle strobe and one main status frame per cyclic cycle
// assumes: bench sets mode 0 silent, 1 intact, 2 corrupt, on core_clk
`timescale 1ns/10ps
module jesl_peer_model #(
  parameter int CYC = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench control
  input wire logic [1:0] mode,
  input wire logic [5:0] dev,
  input wire logic estop,
  // network side
  output jesl_pkg::jesl_frame_t frame,
  output logic cycle_start
);
  logic [4:0] cnt_r;
  // one status frame in our slot
  // slot fixed four clocks after the cycle strobe
  // fields are scrambled between frames so stale values never look valid
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      frame <= '0;
      cycle_start <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 5'(CYC - 1)) ? 5'h00 : cnt_r + 5'h01;
      cycle_start <= (cnt_r == 5'h00);
      frame <= (cnt_r == 5'h04) ? {mode != 2'h0, dev, mode == 2'h1, estop}
                                : {1'b0, ~frame[7:0]};
    end
  end
endmodule

// [test/jesl_top_asserts.sv]
// port checker for the joint error stop link
// assumes: bound to jesl_top, apb with full strobes on core_clk
`timescale 1ns/10ps
module jesl_top_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  // network and axis
  input wire jesl_pkg::jesl_frame_t frame,
  input wire logic own_err_irq,
  input wire logic own_stopping,
  input wire logic axis_err_stop,
  input wire logic axis_err_irq,
  input wire logic stop_req_out
);
  logic [5:0] tgt_r;
  logic fen_r, ren_r, sen_r;
  wire acc = psel && penable;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // shadow of write-only settings, since they cannot be read back
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {tgt_r, fen_r, ren_r, sen_r} <= '0;
    end else if (acc && pwrite) begin
      if (paddr == 12'h000 && pstrb[1]) {fen_r, tgt_r} <= pwdata[14:8];
      if (paddr == 12'h004 && pstrb[3]) {ren_r, sen_r} <= pwdata[31:30];
    end
  end
  a_peer_follow: assert property ((frame.valid && frame.crc_ok && frame.err_stop
    && frame.dev == tgt_r && fen_r) ##1 (fen_r && ren_r) |=> axis_err_stop)
    else $error("no follow");
  a_irq_stops: assert property (axis_err_irq |-> axis_err_stop) else $error("irq alone");
  a_irq_single: assert property (axis_err_irq |=> !axis_err_irq) else $error("irq held");
  a_send_on: assert property (sen_r && fen_r && own_err_irq && own_stopping
    |=> stop_req_out) else $error("stop not sent");
  a_send_off: assert property (!sen_r |=> !stop_req_out) else $error("sent while off");
  a_irq_no_stop: assert property (!own_stopping |=> !stop_req_out) else $error("no stop");
  a_unmapped: assert property (acc && paddr > 12'h017 |-> pslverr) else $error("unmapped");
  a_wo_read: assert property (acc && !pwrite && paddr == 12'h000 |-> pslverr)
    else $error("wo read ok");
endmodule
bind jesl_top jesl_top_asserts chk_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .frame(frame), .own_err_irq(own_err_irq), .own_stopping(own_stopping),
  .axis_err_stop(axis_err_stop), .axis_err_irq(axis_err_irq), .stop_req_out(stop_req_out));

// [test/jesl_top_test.sv]
// bench for the joint error stop link: apb access and peer frame cases
// assumes: peer model frames every 16 clocks in a fixed slot
`timescale 1ns/10ps
module jesl_top_test;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, estop;
  logic own_err_irq, own_stopping, axis_err_stop, axis_err_irq, stop_req_out, cycle_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] mode;
  jesl_pkg::jesl_frame_t frame;
  int n_fail = 0, samples_checked = 0, n_irq = 0, n_stop = 0, n0, i;
  jesl_peer_model peer_u (.core_clk(core_clk), .rst_n(rst_n), .mode(mode), .dev(6'h3f),
    .estop(estop), .frame(frame), .cycle_start(cycle_start));
  jesl_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame(frame), .cycle_start(cycle_start),
    .own_err_irq(own_err_irq), .own_stopping(own_stopping), .axis_err_stop(axis_err_stop),
    .axis_err_irq(axis_err_irq), .stop_req_out(stop_req_out));
  // clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // pulse counters, so one-cycle outputs are never missed
  always @(posedge core_clk) begin
    n_irq <= n_irq + int'(axis_err_irq === 1'b1);
    n_stop <= n_stop + int'(axis_err_stop === 1'b1);
  end
  task automatic summarize;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", s, e, g);
    end
  endtask
  // one apb transfer; data and error taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      n_fail++;
      summarize();
    end
  endtask
  // reset, then the tests in order
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, estop, own_err_irq, own_stopping} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 2'h1;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, 12'h008, 0);
    chk("count", 0, rd[15:8]);
    apb(0, 12'h018, 0);
    chk("unmapped err", 1, err);
    apb(0, 12'h000, 0);
    chk("wo read err", 1, err);
    $display("reset test done");
    // peer 63 is the slot just before ours
    apb(1, 12'h000, 32'h0000_7f00);
    apb(1, 12'h004, 32'hc000_0000);
    estop <= 1'b1;
    n0 = n_stop;
    repeat (40) @(posedge core_clk);
    chk("peer stop", 1, n_stop > n0);
    apb(1, 12'h004, 32'h4000_0000);
    // let a stop already in flight from the old setting pass first
    repeat (3) @(posedge core_clk);
    n0 = n_stop;
    repeat (40) @(posedge core_clk);
    chk("stop, receive off", n0, n_stop);
    estop <= 1'b0;
    own_err_irq <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("irq only", 0, stop_req_out);
    @(posedge core_clk);
    own_stopping <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk("own stop out", 1, stop_req_out);
    apb(1, 12'h004, 32'h0);
    repeat (3) @(negedge core_clk);
    chk("send off", 0, stop_req_out);
    @(posedge core_clk);
    {own_err_irq, own_stopping} <= 2'h0;
    $display("stop link test done");
    apb(1, 12'h00c, 32'h0003_0000);
    apb(1, 12'h014, 32'h0000_0031);
    mode <= 2'h2;
    for (i = 0; i < 100 && axis_err_irq !== 1'b1; i++) @(negedge core_clk);
    chk("limit stop", 3, {axis_err_irq, axis_err_stop});
    apb(1, 12'h000, 32'h0000_3f00);
    apb(0, 12'h008, 0);
    chk("count", 3, rd[15:8]);
    apb(0, 12'h010, 0);
    chk("status", 1, rd[20]);
    apb(1, 12'h014, 32'h0000_0031);
    apb(0, 12'h008, 0);
    chk("cleared", 0, rd[15:8]);
    apb(1, 12'h000, 32'h0000_7f00);
    n0 = n_irq;
    // two errors, one good frame, two errors: the limit of three is never met
    for (i = 0; i < 5; i++) begin
      mode <= (i == 2) ? 2'h1 : 2'h2;
      repeat (16) @(posedge core_clk);
    end
    mode <= 2'h1;
    chk("run restart", n0, n_irq);
    apb(0, 12'h008, 0);
    chk("count", 4, rd[15:8]);
    apb(1, 12'h00c, 32'h0);
    // two silent cycles: each missing target frame counts one error
    mode <= 2'h0;
    repeat (32) @(posedge core_clk);
    mode <= 2'h1;
    repeat (16) @(posedge core_clk);
    apb(0, 12'h008, 0);
    chk("count missing", 6, rd[15:8]);
    mode <= 2'h2;
    n0 = n_irq;
    repeat (16 * 260) @(posedge core_clk);
    chk("limit zero", n0, n_irq);
    apb(0, 12'h008, 0);
    chk("count top", 8'hff, rd[15:8]);
    $display("counting test done");
    // second reset in mid-run must clear the saturated count
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(0, 12'h008, 0);
    chk("count after reset", 0, rd[15:8]);
    $display("reset again test done");
    summarize();
  end
endmodule
